// ---- fpda_regs.svh ----
// ****************************************************************
// ****************************************************************
`ifndef FPDA_REGS_SVH
`define FPDA_REGS_SVH
// ****************************************************************
// Register offsets, fields and reset values.
// ****************************************************************
`define FPDA_CTRL_OFS 8'h00
`define FPDA_MANUAL_OFS 8'h04
`define FPDA_SPIN_OFS 8'h08
`define FPDA_RAMP_OFS 8'h0c
`define FPDA_THRESH_OFS 8'h10
`define FPDA_STATUS_OFS 8'h14
`define FPDA_FORCE_POS 0
`define FPDA_ALT_POS 1
`define FPDA_LOWF_POS 2
`define FPDA_MAN_POS 3
`define FPDA_SPIN_TIME_POS 8
`define FPDA_BIND_POS 8
`define FPDA_STAT_DUTY1_POS 16
`define FPDA_STAT_SPIN_POS 30
`define FPDA_CTRL_RST 32'h0000_0000
`define FPDA_MANUAL_RST 32'h0000_0000
`define FPDA_SPIN_RST 32'h0000_020d
`define FPDA_RAMP_RST 32'h0000_ff01
`define FPDA_THRESH_RST 32'h0000_ffff
`define FPDA_RESP_OKAY 2'h0
`define FPDA_RESP_SLVERR 2'h2
// ****************************************************************
// Duty scale, step tables and timing.
// ****************************************************************
`define FPDA_FULL 9'h1c0
`define FPDA_TOP_CODE 4'hd
`define FPDA_HI_BASE 84
`define FPDA_HI_STEP 28
`define FPDA_ALT_BASE 96
`define FPDA_ALT_STEP 16
`define FPDA_ALT_KNEE 4'ha
`define FPDA_ALT_WIDE 64
`define FPDA_ALT_OFFS 384
`define FPDA_MS_NS 1000000
`define FPDA_CLK_NS 100
`define FPDA_MS_W 24
`endif

// ---- fpda_pkg.sv ----
package fpda_pkg;
   // Duty on a scale where full drive is 448 counts.
   typedef logic [8:0] fpda_duty_type;
   typedef logic [3:0] fpda_code_type;
   // Fan protection events, one bit per zone or tachometer.
   typedef struct packed {
      logic [3:0] zone_above_limit;
      logic [3:0] zone_below_hyst;
      logic [3:0] tach_over_limit;
   } fpda_limit_type;
   // Automatic algorithm requests for one output.
   typedef struct packed {
      fpda_code_type auto_code;
      fpda_duty_type feedback_duty;
   } fpda_demand_type;
   typedef struct packed {
      logic en;
      fpda_code_type code;
   } fpda_ramp_state_type;
   typedef struct packed {
      logic awrdy, wrdy, arrdy, bvalid, rvalid, aw_have, w_have;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata, wdata;
      logic [7:0] awaddr;
      logic [3:0] wstrb;
      logic [31:0] ctrl, manual, spin, ramp, thresh;
      logic [3:0] boost;
      logic [1:0] proc_over, prev_zero, pwm;
      logic [23:0] ms_cnt;
      logic ms_tick, rtick, alt;
      logic [7:0] iv_cnt, pre_cnt;
      logic [1:0][7:0] spin_cnt;
      logic [1:0][8:0] req, duty;
      logic [8:0] pcnt;
   } fpda_state_type;
endpackage : fpda_pkg

// ---- fpda_ramp.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fpda_regs.svh"
module fpda_ramp
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Interval pulse and hot level.
   input wire logic tick,
   input wire logic hot,
   // Step code requested by the other functions.
   input wire logic [3:0] other,
   // Ramp state.
   output var logic active,
   output var logic [3:0] code
);
   fpda_pkg::fpda_ramp_state_type s, n;

   // Saturating step-up helper.
   function automatic logic [3:0] step_up(input logic [3:0] c);
      step_up = (c >= `FPDA_TOP_CODE) ? `FPDA_TOP_CODE : 4'(c + 4'h1);
   endfunction : step_up

   // Computes the next ramp state.
   always_comb
   begin
      n = s;
      if (!s.en)
      begin
         if (hot)
         begin
            n.en = 1'b1;
            n.code = step_up(other);
         end
      end
      else
      begin
         if (tick)
            n.code = hot ? step_up(s.code) : ((s.code == 4'h0) ? 4'h0 : 4'(s.code - 4'h1));
         if (!hot && (s.code < other))
         begin
            n.en = 1'b0;
            n.code = 4'h0;
         end
      end
      if (!aresetn)
         n = '0;
   end

   // Registers the ramp state.
   always_ff @(posedge aclk)
      s <= n;

   assign active = s.en;
   assign code = s.code;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_ramp_capture: assert property (!s.en && hot |=> s.en && s.code == step_up($past(other)))
      else $error("ramp did not capture other duty plus one step");
   a_ramp_stays: assert property (s.en && hot && !tick |=> s.en && $stable(s.code))
      else $error("enabled ramp restarted its capture");
   a_ramp_down: assert property (s.en && tick && !hot && s.code >= other && s.code != 4'h0
      |=> s.code == $past(s.code) - 4'h1)
      else $error("released ramp did not step down");
   a_ramp_top: assert property (s.code <= `FPDA_TOP_CODE)
      else $error("ramp passed full duty");
   a_ramp_off: assert property (s.en && !hot && s.code < other |=> !s.en)
      else $error("ramp below other duty stayed enabled");
   c_ramp_cycle: cover property (!s.en && hot ##1 s.en [*2] ##[1:1000] !s.en);
endmodule : fpda_ramp
`default_nettype wire

// ---- fpda_arbiter.sv ----
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fpda_regs.svh"
module fpda_arbiter
#(
   parameter int MS_CYCLES = `FPDA_MS_NS / `FPDA_CLK_NS,
   parameter int LOW_DIV = 16
)
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output var logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output var logic s_axi_wready,
   output var logic [1:0] s_axi_bresp,
   output var logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output var logic s_axi_arready,
   output var logic [31:0] s_axi_rdata,
   output var logic [1:0] s_axi_rresp,
   output var logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Hot indications.
   input wire logic regulator_one_hot_input_n,
   input wire logic regulator_two_hot_input_n,
   input wire logic [7:0] processor_one_hot_input,
   input wire logic [7:0] processor_two_hot_input,
   input wire logic [1:0] processor_hot_valid,
   // Protection events and automatic requests.
   input wire fpda_pkg::fpda_limit_type limits,
   input wire fpda_pkg::fpda_demand_type [1:0] demand,
   // Fan drive.
   output var logic [1:0] pwm_out
);
   // ****************************************************************
   // Elaboration checks.
   // ****************************************************************
   if (MS_CYCLES < 2 || MS_CYCLES >= (1 << `FPDA_MS_W))
   begin : g_bad_ms
      $error("MS_CYCLES out of range");
   end
   if (LOW_DIV < 1 || LOW_DIV > 256)
   begin : g_bad_div
      $error("LOW_DIV out of range");
   end

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   // Converts a step code to duty under the selected table.
   function automatic logic [8:0] map_code(input logic alt, input logic [3:0] c);
      if (c == 4'h0)
         map_code = 9'h000;
      else if (c > `FPDA_TOP_CODE)
         map_code = `FPDA_FULL;
      else if (!alt)
         map_code = 9'(`FPDA_HI_BASE + `FPDA_HI_STEP * int'(c));
      else if (c <= `FPDA_ALT_KNEE)
         map_code = 9'(`FPDA_ALT_BASE + `FPDA_ALT_STEP * int'(c));
      else
         map_code = 9'(`FPDA_ALT_WIDE * int'(c) - `FPDA_ALT_OFFS);
   endfunction : map_code

   // Smallest step code whose duty covers the given duty.
   function automatic logic [3:0] to_code(input logic alt, input logic [8:0] d);
      to_code = `FPDA_TOP_CODE;
      for (int c = 13; c >= 0; c--)
         if (map_code(alt, 4'(c)) >= d)
            to_code = 4'(c);
   endfunction : to_code

   function automatic logic [8:0] max9(input logic [8:0] a, input logic [8:0] b);
      max9 = (a > b) ? a : b;
   endfunction : max9

   // Merges write data into a register by byte strobes.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
      merge = old;
      for (int b = 0; b < 4; b++)
         if (st[b])
            merge[8*b +: 8] = d[8*b +: 8];
   endfunction : merge

   // ****************************************************************
   // State and ramp instances.
   // ****************************************************************
   fpda_pkg::fpda_state_type s, n;
   logic full, bnd;
   logic [7:0] rhot, ract;
   logic [7:0][3:0] rcode;
   logic [1:0] man_en;
   logic [1:0][8:0] man_duty, auto_duty, rdu, base, nospin;
   logic [1:0][3:0] ocode;
   logic [1:0] hot_n;
   logic [1:0][7:0] pmeas;
   logic [7:0] rd_addr;

   // Ramps 0-3 follow the regulator inputs, 4-7 the processor inputs; bit 0 picks the output.
   for (genvar k = 0; k < 8; k++)
   begin : g_ramp
      fpda_ramp u_ramp
      (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick(s.rtick),
         .hot(rhot[k]),
         .other(ocode[k % 2]),
         .active(ract[k]),
         .code(rcode[k])
      );
   end

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   // Bus slave, timers, arbitration and fan drive.
   always_comb
   begin
      n = s;
      rhot = '0;
      man_en = s.ctrl[`FPDA_MAN_POS +: 2];
      man_duty = '0;
      auto_duty = '0;
      rdu = '0;
      base = '0;
      nospin = '0;
      ocode = '0;
      bnd = 1'b0;
      rd_addr = s_axi_araddr;
      hot_n = {regulator_two_hot_input_n, regulator_one_hot_input_n};
      pmeas = {processor_two_hot_input, processor_one_hot_input};
      // Write path: address and data taken in either order.
      if (s_axi_awvalid && s.awrdy)
      begin
         n.aw_have = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wrdy)
      begin
         n.w_have = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready)
         n.bvalid = 1'b0;
      if (n.aw_have && n.w_have && !s.bvalid)
      begin
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `FPDA_RESP_OKAY;
         unique case (n.awaddr)
            `FPDA_CTRL_OFS: n.ctrl = merge(s.ctrl, n.wdata, n.wstrb);
            `FPDA_MANUAL_OFS: n.manual = merge(s.manual, n.wdata, n.wstrb);
            `FPDA_SPIN_OFS: n.spin = merge(s.spin, n.wdata, n.wstrb);
            `FPDA_RAMP_OFS: n.ramp = merge(s.ramp, n.wdata, n.wstrb);
            `FPDA_THRESH_OFS: n.thresh = merge(s.thresh, n.wdata, n.wstrb);
            `FPDA_STATUS_OFS: n.bresp = `FPDA_RESP_OKAY;
            default: n.bresp = `FPDA_RESP_SLVERR;
         endcase
      end
      n.awrdy = !n.aw_have && !n.bvalid;
      n.wrdy = !n.w_have && !n.bvalid;
      // Read path: one word answered the cycle after the address is taken.
      if (s.rvalid && s_axi_rready)
         n.rvalid = 1'b0;
      if (s_axi_arvalid && s.arrdy)
      begin
         n.rvalid = 1'b1;
         n.rresp = `FPDA_RESP_OKAY;
         n.rdata = 32'h0000_0000;
         unique case (rd_addr)
            `FPDA_CTRL_OFS: n.rdata = s.ctrl;
            `FPDA_MANUAL_OFS: n.rdata = s.manual;
            `FPDA_SPIN_OFS: n.rdata = s.spin;
            `FPDA_RAMP_OFS: n.rdata = s.ramp;
            `FPDA_THRESH_OFS: n.rdata = s.thresh;
            `FPDA_STATUS_OFS:
            begin
               n.rdata[8:0] = s.req[0];
               n.rdata[`FPDA_STAT_DUTY1_POS +: 9] = s.req[1];
               n.rdata[`FPDA_STAT_SPIN_POS] = s.spin_cnt[0] != 8'h00;
               n.rdata[`FPDA_STAT_SPIN_POS + 1] = s.spin_cnt[1] != 8'h00;
            end
            default: n.rresp = `FPDA_RESP_SLVERR;
         endcase
      end
      n.arrdy = !n.rvalid;
      // Millisecond tick and ramp interval tick.
      n.ms_tick = 1'b0;
      n.rtick = 1'b0;
      if (s.ms_cnt == `FPDA_MS_W'(MS_CYCLES - 1))
      begin
         n.ms_cnt = '0;
         n.ms_tick = 1'b1;
      end
      else
         n.ms_cnt = s.ms_cnt + `FPDA_MS_W'(1);
      if (s.ms_tick)
      begin
         if (9'(s.iv_cnt) + 9'h001 >= 9'(s.ramp[7:0]))
         begin
            n.iv_cnt = 8'h00;
            n.rtick = 1'b1;
         end
         else
            n.iv_cnt = s.iv_cnt + 8'h01;
      end
      // Table choice and full-speed conditions.
      n.alt = s.ctrl[`FPDA_ALT_POS] | s.ctrl[`FPDA_LOWF_POS];
      n.boost = limits.zone_above_limit | (s.boost & ~limits.zone_below_hyst);
      full = (|limits.zone_above_limit) | (|s.boost) | (|limits.tach_over_limit) | s.ctrl[`FPDA_FORCE_POS];
      // Processor measurements latch over-threshold on each new sample.
      for (int p = 0; p < 2; p++)
         if (processor_hot_valid[p])
            n.proc_over[p] = pmeas[p] > s.thresh[8*p +: 8];
      for (int k = 0; k < 8; k++)
         rhot[k] = s.ramp[`FPDA_BIND_POS + k] &
                   ((k >= 4) ? s.proc_over[(k / 2) % 2] : !hot_n[(k / 2) % 2]);
      // Per output arbitration.
      for (int i = 0; i < 2; i++)
      begin
         man_duty[i] = map_code(s.alt, s.manual[4*i +: 4]);
         auto_duty[i] = max9(map_code(s.alt, demand[i].auto_code),
                             (demand[i].feedback_duty > `FPDA_FULL) ? `FPDA_FULL : demand[i].feedback_duty);
         for (int k = 0; k < 8; k++)
            if (k % 2 == i && ract[k] && s.ramp[`FPDA_BIND_POS + k])
               rdu[i] = max9(rdu[i], map_code(s.alt, rcode[k]));
         nospin[i] = max9(full ? `FPDA_FULL : 9'h000, man_en[i] ? man_duty[i] : auto_duty[i]);
         base[i] = nospin[i];
         if (!man_en[i] && s.spin_cnt[i] != 8'h00)
            base[i] = max9(base[i], map_code(s.alt, s.spin[3:0]));
         ocode[i] = to_code(s.alt, base[i]);
         nospin[i] = max9(nospin[i], rdu[i]);
         n.req[i] = max9(base[i], rdu[i]);
         // Outside manual mode, spin-up starts when the other functions leave zero.
         n.prev_zero[i] = nospin[i] == 9'h000;
         if (s.spin_cnt[i] != 8'h00 && s.ms_tick)
            n.spin_cnt[i] = s.spin_cnt[i] - 8'h01;
         if (s.prev_zero[i] && nospin[i] != 9'h000 && !man_en[i])
            n.spin_cnt[i] = (s.spin[`FPDA_SPIN_TIME_POS +: 8] == 8'h00) ? 8'h01 :
                            s.spin[`FPDA_SPIN_TIME_POS +: 8];
      end
      // Period counter; low frequency mode slows it by the prescaler.
      n.pre_cnt = 8'h00;
      if (s.ctrl[`FPDA_LOWF_POS] && s.pre_cnt != 8'(LOW_DIV - 1))
         n.pre_cnt = s.pre_cnt + 8'h01;
      if (n.pre_cnt == 8'h00)
      begin
         bnd = s.pcnt == `FPDA_FULL - 9'h001;
         n.pcnt = bnd ? 9'h000 : s.pcnt + 9'h001;
      end
      if (bnd)
         n.duty = s.req;
      for (int i = 0; i < 2; i++)
         n.pwm[i] = n.pcnt < n.duty[i];
      if (!aresetn)
      begin
         n = '0;
         n.ctrl = `FPDA_CTRL_RST;
         n.manual = `FPDA_MANUAL_RST;
         n.spin = `FPDA_SPIN_RST;
         n.ramp = `FPDA_RAMP_RST;
         n.thresh = `FPDA_THRESH_RST;
         n.prev_zero = 2'h3;
      end
   end

   // Registers the whole state.
   always_ff @(posedge aclk)
      s <= n;

   // Outputs come straight from state flops.
   assign s_axi_awready = s.awrdy;
   assign s_axi_wready = s.wrdy;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arrdy;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign pwm_out = s.pwm;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_force_full: assert property (s.ctrl[`FPDA_FORCE_POS] |=> s.req[0] == `FPDA_FULL && s.req[1] == `FPDA_FULL)
      else $error("force bit did not give full duty");
   a_boost_full: assert property (s.boost != 4'h0 || limits.tach_over_limit != 4'h0 |=> s.req[1] == `FPDA_FULL)
      else $error("boost or tach fault did not give full duty");
   a_alt_select: assert property (s.ctrl[`FPDA_LOWF_POS] |=> s.alt)
      else $error("low frequency did not select alternate table");
   a_manual_only: assert property (man_en[0] && !full && rdu[0] == 9'h000 |=> s.req[0] == $past(man_duty[0]))
      else $error("manual request not sole winner");
   a_alt_table: assert property (s.alt && man_en[0] && !full && rdu[0] == 9'h000 && s.manual[3:0] == 4'hb
      |=> s.req[0] == 9'h140)
      else $error("alternate table value wrong");
   a_high_table: assert property (!s.alt && man_en[0] && !full && rdu[0] == 9'h000 && s.manual[3:0] == 4'h2
      |=> s.req[0] == 9'h08c)
      else $error("default table value wrong");
   a_auto_floor: assert property (!man_en[0] |=> s.req[0] >= $past(auto_duty[0]))
      else $error("automatic request lost");
   a_manual_floor: assert property (man_en[1] |=> s.req[1] >= $past(man_duty[1]))
      else $error("manual request lost");
   a_period_hold: assert property (!bnd |=> $stable(s.duty))
      else $error("duty changed inside a period");
   a_spin_start: assert property (s.prev_zero[0] && nospin[0] != 9'h000 && !man_en[0] |=> s.spin_cnt[0] != 8'h00)
      else $error("spin-up not triggered");
   c_spin_start: cover property (s.prev_zero[0] && nospin[0] != 9'h000 && !man_en[0]);
   c_manual_win: cover property (man_en[1] && !full ##1 s.req[1] != 9'h000);
   c_full_speed: cover property (full ##1 s.req[0] == `FPDA_FULL);
endmodule : fpda_arbiter
`default_nettype wire

// ---- fpda_fan_stage.sv ----
`timescale 1ns/10ps
`default_nettype none
module fpda_fan_stage
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Drive from the arbiter.
   input wire logic [1:0] pwm,
   // Accumulated on-time of each stage.
   output var logic [1:0][31:0] on_cycles
);
   // ****************************************************************
   // Power stage integrates on-time, as its output filter would.
   // ****************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         on_cycles <= '0;
      end
      else
      begin
         on_cycles[0] <= on_cycles[0] + 32'(pwm[0]);
         on_cycles[1] <= on_cycles[1] + 32'(pwm[1]);
      end
   end
endmodule : fpda_fan_stage
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ****************************************************************
   // Signals, cases and instances.
   // ****************************************************************
   typedef struct packed {
      logic [7:0] ctrl, manual;
      logic [3:0] a0, a1;
      logic [8:0] f0, f1, e0, e1;
   } fpda_row_type;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, pwm_out, resp;
   logic [31:0] s_axi_rdata, rd, t0, t1;
   logic regulator_one_hot_input_n = 1'b1, regulator_two_hot_input_n = 1'b1;
   logic [7:0] processor_one_hot_input = 8'h00, processor_two_hot_input = 8'h00;
   logic [1:0] processor_hot_valid = 2'h0;
   fpda_pkg::fpda_limit_type limits = '0;
   fpda_pkg::fpda_demand_type [1:0] demand = '0;
   logic [1:0][31:0] on_cycles;
   int err_count = 0;
   int compares = 0;
   logic [7:0] rst_addr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   logic [31:0] rst_val [5] = '{32'h0, 32'h0, 32'h0000_020d, 32'h0000_ff01, 32'h0000_ffff};
   // Control, manual, codes, feedback, expected requests of both outputs.
   fpda_row_type rows [8] = '{
      '{8'h00, 8'h00, 4'h3, 4'hc, 9'h000, 9'h000, 9'h0a8, 9'h1a4},
      '{8'h02, 8'h00, 4'h3, 4'hb, 9'h0a0, 9'h000, 9'h0a0, 9'h140},
      '{8'h04, 8'h00, 4'hc, 4'h1, 9'h000, 9'h000, 9'h180, 9'h070},
      '{8'h08, 8'h57, 4'hc, 4'h1, 9'h000, 9'h000, 9'h118, 9'h070},
      '{8'h18, 8'h02, 4'hc, 4'h5, 9'h000, 9'h000, 9'h08c, 9'h000},
      '{8'h01, 8'h00, 4'h0, 4'h0, 9'h000, 9'h000, 9'h1c0, 9'h1c0},
      '{8'h00, 8'h00, 4'he, 4'h1, 9'h000, 9'h12c, 9'h1c0, 9'h12c},
      '{8'h0a, 8'h0b, 4'hc, 4'h1, 9'h000, 9'h000, 9'h140, 9'h070}};
   fpda_arbiter #(.MS_CYCLES(20), .LOW_DIV(2)) i_dut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .regulator_one_hot_input_n, .regulator_two_hot_input_n, .processor_one_hot_input,
      .processor_two_hot_input, .processor_hot_valid, .limits, .demand, .pwm_out
   );
   fpda_fan_stage i_fan (.aclk, .aresetn, .pwm(pwm_out), .on_cycles);
   // The clock toggles every half period of 100 ns.
   always #50 aclk = ~aclk;
   // ****************************************************************
   // Bus cycles, comparison and closing.
   // ****************************************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Readies are registered, so the value at the falling edge is the one sampled next.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, ra, rw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge aclk);
         ra = s_axi_awready === 1'b1;
         rw = s_axi_wready === 1'b1;
         @(posedge aclk);
         ta = ta | ra;
         tw = tw | rw;
         s_axi_awvalid <= !ta;
         s_axi_wvalid <= !tw;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   // Compares both request fields of the status word, spin-up flags masked.
   task automatic st(input logic [31:0] e);
      axi_rd(8'h14);
      chk("status", e, rd & 32'h01ff_01ff);
   endtask : st
   // Presents one processor measurement with its one-cycle valid pulse.
   task automatic proc_meas(input logic [7:0] m);
      processor_one_hot_input <= m;
      processor_hot_valid <= 2'h1;
      @(posedge aclk);
      processor_hot_valid <= 2'h0;
   endtask : proc_meas
   // Measures on-time over exactly one output period.
   task automatic meas(input logic [31:0] c, input int win, input logic [31:0] e0, input logic [31:0] e1);
      axi_wr(8'h00, c);
      repeat (2000) @(posedge aclk);
      t0 = on_cycles[0];
      t1 = on_cycles[1];
      repeat (win) @(posedge aclk);
      chk("on time 0", e0, on_cycles[0] - t0);
      chk("on time 1", e1, on_cycles[1] - t1);
   endtask : meas
   task automatic end_of_test();
      if (err_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // Watchdog cuts a hang short.
   initial
   begin
      repeat (30000) @(posedge aclk);
      err_count++;
      end_of_test();
   end
   // Main sequence: reset, table of cases, then the awkward cases.
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (rst_addr[i])
      begin
         axi_rd(rst_addr[i]);
         chk("reset value", rst_val[i], rd);
      end
      axi_rd(8'h18);
      chk("read resp", 32'h2, {30'h0, resp});
      axi_wr(8'h18, 32'h1);
      chk("write resp", 32'h2, {30'h0, resp});
      axi_wr(8'h14, 32'hffff_ffff);
      chk("status write resp", 32'h0, {30'h0, resp});
      foreach (rows[i])
      begin
         axi_wr(8'h00, {24'h0, rows[i].ctrl});
         axi_wr(8'h04, {24'h0, rows[i].manual});
         demand <= {rows[i].a1, rows[i].f1, rows[i].a0, rows[i].f0};
         repeat (100) @(posedge aclk);
         axi_rd(8'h14);
         chk("request 0", {23'h0, rows[i].e0}, {23'h0, rd[8:0]});
         chk("request 1", {23'h0, rows[i].e1}, {23'h0, rd[24:16]});
      end
      axi_wr(8'h00, 32'h0);
      demand <= {13'h0, 4'h3, 9'h0};
      limits.zone_above_limit <= 4'h4;
      @(posedge aclk);
      limits.zone_above_limit <= 4'h0;
      repeat (5) @(posedge aclk);
      st(32'h01c0_01c0);
      limits.zone_below_hyst <= 4'h4;
      // Output 1 was nonzero when full speed began, so no spin-up runs and it falls to zero once the boost clears.
      repeat (60) @(posedge aclk);
      st(32'h0000_00a8);
      limits.zone_below_hyst <= 4'h0;
      limits.tach_over_limit <= 4'h2;
      repeat (3) @(posedge aclk);
      st(32'h01c0_01c0);
      limits.tach_over_limit <= 4'h0;
      demand <= '0;
      // Lets the spin-up started by the tachometer fault on output 1 expire.
      repeat (60) @(posedge aclk);
      demand <= {13'h0, 4'h2, 9'h0};
      repeat (3) @(posedge aclk);
      axi_rd(8'h14);
      chk("spin start", 32'h4000_01c0, rd);
      repeat (60) @(posedge aclk);
      axi_rd(8'h14);
      chk("spin end", 32'h0000_008c, rd);
      axi_wr(8'h0c, 32'h0000_0105);
      demand <= {13'h0, 4'h3, 9'h0};
      repeat (3) @(posedge aclk);
      regulator_one_hot_input_n <= 1'b0;
      repeat (3) @(posedge aclk);
      st(32'h0000_00c4);
      repeat (1300) @(posedge aclk);
      st(32'h0000_01c0);
      regulator_one_hot_input_n <= 1'b1;
      repeat (60) @(posedge aclk);
      regulator_one_hot_input_n <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_rd(8'h14);
      chk("ramp kept", 32'h1, {31'h0, rd[8:0] >= 9'h1a4});
      regulator_one_hot_input_n <= 1'b1;
      repeat (1600) @(posedge aclk);
      st(32'h0000_00a8);
      axi_wr(8'h0c, 32'h0000_1005);
      axi_wr(8'h10, 32'h0000_ff40);
      proc_meas(8'h50);
      repeat (3) @(posedge aclk);
      st(32'h0000_00c4);
      proc_meas(8'h30);
      repeat (1600) @(posedge aclk);
      st(32'h0000_00a8);
      demand <= {4'hd, 9'h0, 4'h5, 9'h0};
      meas(32'h0, 448, 32'd224, 32'd448);
      meas(32'h4, 896, 32'd352, 32'd896);
      // A reset in mid-run must bring the control register back to its reset value.
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(8'h00);
      chk("reset value", 32'h0, rd);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
